// ### design/stl_bound_cmp.sv
// One side of the allowed range: span edge widened by the margin
`timescale 1ns/100ps
module stl_bound_cmp #(
  parameter bit UPPER = 1'b0
) (
  input  wire logic                i_clk,
  input  wire logic                i_nrst,
  input  wire stl_pkg::stl_wide_type i_rel,
  input  wire stl_pkg::stl_wide_type i_edge,
  input  wire logic [31:0]         i_margin,
  output logic                     o_beyond
);
  import stl_pkg::*;

  stl_cmp_type      r;
  stl_cmp_type      next_r;
  logic signed [34:0] lim;
  logic signed [34:0] rel_x;

  always_comb
  begin
    next_r = r;
    rel_x  = 35'(i_rel);
    // Two extra bits keep edge plus margin from wrapping
    if (UPPER)
    begin
      lim = 35'(i_edge) + $signed({3'h0, i_margin});
      next_r.beyond = rel_x > lim;
    end
    else
    begin
      lim = 35'(i_edge) - $signed({3'h0, i_margin});
      next_r.beyond = rel_x < lim;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      r <= '0;
    else
      r <= next_r;
  end

  assign o_beyond = r.beyond;
endmodule

// ### design/stl_params.svh
// Offsets, field positions, reset values and counts for the travel limit
`ifndef STL_PARAMS_SVH
`define STL_PARAMS_SVH

// Register byte offsets
`define STL_OFS_CTRL     5'h00
`define STL_OFS_MARGIN   5'h04
`define STL_OFS_MODE     5'h08
`define STL_OFS_STATUS   5'h0C
`define STL_OFS_MASK     5'h10
`define STL_OFS_STATE    5'h14
`define STL_OFS_SPAN_LO  5'h18
`define STL_OFS_SPAN_HI  5'h1C

// Field positions
`define STL_CTRL_ALM_CLR   0
`define STL_MODE_CM_LSB    0
`define STL_MODE_CM_MSB    3
`define STL_MODE_AS_LSB    4
`define STL_MODE_AS_MSB    6
`define STL_MODE_OS_LSB    8
`define STL_MODE_OS_MSB    10
`define STL_EV_ALARM       0
`define STL_EV_OVF         1
`define STL_ST_ALARM       0
`define STL_ST_ARMED       1
`define STL_ST_OVF         2
`define STL_ST_CODE_LSB    8
`define STL_ST_CODE_MSB    15

// Reset values
`define STL_RST_MARGIN     32'h0000_0000
`define STL_RST_MODE       4'h0
`define STL_RST_SEQ        3'h0
`define STL_RST_EV         2'h0

// Qualifying control modes and overtravel hold sequence
`define STL_CM_POS         4'h0
`define STL_CM_POS_VEL     4'h3
`define STL_CM_POS_TRQ     4'h4
`define STL_CM_FULL        4'h6
`define STL_OT_SEQ_HOLD    3'h2

// Alarm code 34 and travel bound 2147483647 counts
`define STL_ALARM_CODE     8'h22
`define STL_TRAVEL_MAX     33'sh0_7FFF_FFFF

// Cycles the check stays off after a span clear while the pipeline refills
`define STL_QUIET_CYC      2'h3

`endif

// ### design/stl_pkg.sv
// Types shared by the travel limit modules
package stl_pkg;

  typedef logic signed [31:0] stl_count_type;
  typedef logic signed [32:0] stl_wide_type;

  typedef struct packed {
    logic          beyond;
  } stl_cmp_type;

  typedef struct packed {
    stl_count_type origin;
    stl_wide_type  cmd;
    stl_wide_type  lo;
    stl_wide_type  hi;
    stl_wide_type  rel;
  } stl_span_type;

  typedef struct packed {
    logic          waitreq;
    logic [31:0]   rdata;
    logic [31:0]   margin;
    logic [3:0]    mode;
    logic [2:0]    alarm_seq;
    logic [2:0]    ot_seq;
    logic [1:0]    status;
    logic [1:0]    mask;
    logic          irq;
    logic          alarm;
    logic [2:0]    stop_seq;
    logic          ovf;
    logic [1:0]    quiet;
  } stl_top_type;

endpackage

// ### design/stl_span.sv
// Commanded span and motor travel, relative to the point of last clear
`timescale 1ns/100ps
module stl_span (
  input  wire logic                  i_clk,
  input  wire logic                  i_nrst,
  input  wire logic                  i_clear,
  input  wire logic                  i_cmd_valid,
  input  wire stl_pkg::stl_count_type i_cmd_delta,
  input  wire stl_pkg::stl_count_type i_motor_pos,
  output stl_pkg::stl_wide_type      o_lo,
  output stl_pkg::stl_wide_type      o_hi,
  output stl_pkg::stl_wide_type      o_rel
);
  import stl_pkg::*;

  stl_span_type r;
  stl_span_type next_r;
  stl_wide_type next_cmd;

  always_comb
  begin
    next_r   = r;
    next_cmd = r.cmd + 33'(i_cmd_delta);
    // Motor travel since clear; 33 bits so a full 32-bit swing is visible
    next_r.rel = 33'(i_motor_pos) - 33'(r.origin);
    if (i_clear)
    begin
      next_r.origin = i_motor_pos;
      next_r.cmd    = '0;
      next_r.lo     = '0;
      next_r.hi     = '0;
      next_r.rel    = '0;
    end
    else if (i_cmd_valid)
    begin
      next_r.cmd = next_cmd;
      if (next_cmd < r.lo)
        next_r.lo = next_cmd;
      if (next_cmd > r.hi)
        next_r.hi = next_cmd;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      r <= '0;
    else
      r <= next_r;
  end

  assign o_lo  = r.lo;
  assign o_hi  = r.hi;
  assign o_rel = r.rel;
endmodule

// ### design/stl_travel_limit.sv
// Software travel limit protection with Avalon-MM register access
//
// Local design decisions: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/100ps
`include "stl_params.svh"

module stl_travel_limit (
  input  wire logic                  i_clk,
  input  wire logic                  i_nrst,
  input  wire logic [4:0]            i_address,
  input  wire logic                  i_read,
  input  wire logic                  i_write,
  input  wire logic [31:0]           i_writedata,
  output logic                       o_waitrequest,
  output logic [31:0]                o_readdata,
  input  wire logic                  i_servo_on,
  input  wire logic                  i_cmd_valid,
  input  wire stl_pkg::stl_count_type i_cmd_delta,
  input  wire stl_pkg::stl_count_type i_motor_pos,
  input  wire logic                  i_dev_clear,
  input  wire logic                  i_ot_inhibit,
  input  wire logic                  i_tune_start,
  input  wire logic                  i_tune_done,
  input  wire logic                  i_tool_test,
  output logic                       o_irq,
  output logic                       o_alarm,
  output logic [7:0]                 o_alarm_code,
  output logic                       o_stop_req,
  output logic [2:0]                 o_stop_seq
);
  import stl_pkg::*;

  stl_top_type  r;
  stl_top_type  next_r;

  stl_wide_type span_lo;
  stl_wide_type span_hi;
  stl_wide_type rel;
  logic         beyond_lo;
  logic         beyond_hi;

  logic         req;
  logic         acc;
  logic         margin_zero;
  logic         mode_ok;
  logic         span_clear;
  logic         armed;
  logic         too_far;
  logic         trip;
  logic         ev_alarm;
  logic         ev_ovf;
  logic         alarm_clr;
  logic [31:0]  rd_mux;
  logic [31:0]  state_word;

  // Power-on reset empties the span tracker as well
  stl_span u_span (
    .i_clk       (i_clk),
    .i_nrst      (i_nrst),
    .i_clear     (span_clear),
    .i_cmd_valid (i_cmd_valid),
    .i_cmd_delta (i_cmd_delta),
    .i_motor_pos (i_motor_pos),
    .o_lo        (span_lo),
    .o_hi        (span_hi),
    .o_rel       (rel)
  );

  // Lower side: span minimum less the margin
  stl_bound_cmp #(
    .UPPER (1'b0)
  ) u_cmp_lo (
    .i_clk    (i_clk),
    .i_nrst   (i_nrst),
    .i_rel    (rel),
    .i_edge   (span_lo),
    .i_margin (r.margin),
    .o_beyond (beyond_lo)
  );

  // Upper side: span maximum plus the margin
  stl_bound_cmp #(
    .UPPER (1'b1)
  ) u_cmp_hi (
    .i_clk    (i_clk),
    .i_nrst   (i_nrst),
    .i_rel    (rel),
    .i_edge   (span_hi),
    .i_margin (r.margin),
    .o_beyond (beyond_hi)
  );

  always_comb
  begin
    req         = i_read | i_write;
    acc         = req & ~r.waitreq;
    margin_zero = r.margin == `STL_RST_MARGIN;

    // Position, position-first combined, full-closed
    mode_ok = (r.mode == `STL_CM_POS) || (r.mode == `STL_CM_POS_VEL) ||
              (r.mode == `STL_CM_POS_TRQ) || (r.mode == `STL_CM_FULL);

    // Every condition that empties the span
    span_clear = ~i_servo_on | margin_zero | i_dev_clear |
                 ((r.ot_seq == `STL_OT_SEQ_HOLD) & i_ot_inhibit) |
                 i_tune_start | i_tune_done;

    // Travel since clear must stay inside the signed bound
    too_far = (rel > `STL_TRAVEL_MAX) || (rel < -`STL_TRAVEL_MAX);

    // Quiet window hides the stale compare right after a clear
    armed = i_servo_on & ~margin_zero & mode_ok &
            ~i_tool_test &
            ~r.ovf &
            ~span_clear & (r.quiet == 2'h0);

    trip     = armed & (beyond_lo | beyond_hi);
    ev_alarm = trip & ~r.alarm;
    ev_ovf   = i_servo_on & ~margin_zero & ~span_clear & too_far & ~r.ovf;

    alarm_clr = acc & i_write & (i_address == `STL_OFS_CTRL) &
                i_writedata[`STL_CTRL_ALM_CLR];

    state_word = 32'h0000_0000;
    state_word[`STL_ST_ALARM] = r.alarm;
    state_word[`STL_ST_ARMED] = armed;
    state_word[`STL_ST_OVF]   = r.ovf;
    state_word[`STL_ST_CODE_MSB:`STL_ST_CODE_LSB] = `STL_ALARM_CODE;

    rd_mux = 32'h0000_0000;
    unique case (i_address)
      `STL_OFS_MARGIN:
        rd_mux = r.margin;
      `STL_OFS_MODE:
      begin
        rd_mux[`STL_MODE_CM_MSB:`STL_MODE_CM_LSB] = r.mode;
        rd_mux[`STL_MODE_AS_MSB:`STL_MODE_AS_LSB] = r.alarm_seq;
        rd_mux[`STL_MODE_OS_MSB:`STL_MODE_OS_LSB] = r.ot_seq;
      end
      `STL_OFS_STATUS:
        rd_mux[1:0] = r.status;
      `STL_OFS_MASK:
        rd_mux[1:0] = r.mask;
      `STL_OFS_STATE:
        rd_mux = state_word;
      `STL_OFS_SPAN_LO:
        rd_mux = span_lo[31:0];
      `STL_OFS_SPAN_HI:
        rd_mux = span_hi[31:0];
      default:
        rd_mux = 32'h0000_0000;
    endcase
  end

  always_comb
  begin
    next_r = r;

    // One wait cycle per access: low only on the accepting edge
    if (req)
      next_r.waitreq = ~r.waitreq;
    else
      next_r.waitreq = 1'b1;

    // Read data is captured a cycle early and held through the accept
    if (i_read & r.waitreq)
      next_r.rdata = rd_mux;

    if (acc & i_write)
    begin
      unique case (i_address)
        `STL_OFS_MARGIN:
          next_r.margin = i_writedata;
        `STL_OFS_MODE:
        begin
          next_r.mode      = i_writedata[`STL_MODE_CM_MSB:`STL_MODE_CM_LSB];
          next_r.alarm_seq = i_writedata[`STL_MODE_AS_MSB:`STL_MODE_AS_LSB];
          next_r.ot_seq    = i_writedata[`STL_MODE_OS_MSB:`STL_MODE_OS_LSB];
        end
        `STL_OFS_MASK:
          next_r.mask = i_writedata[1:0];
        default:
          next_r.mask = r.mask;
      endcase
    end

    // Only bits that the read actually reported are cleared, so an
    // event landing between capture and accept survives
    if (acc & i_read & (i_address == `STL_OFS_STATUS))
      next_r.status = r.status & ~r.rdata[1:0];
    next_r.status[`STL_EV_ALARM] = next_r.status[`STL_EV_ALARM] | ev_alarm;
    next_r.status[`STL_EV_OVF]   = next_r.status[`STL_EV_OVF] | ev_ovf;

    next_r.irq = |(next_r.status & next_r.mask);

    // Alarm holds until software clears it; a live trip wins the clear
    if (alarm_clr)
      next_r.alarm = 1'b0;
    if (trip)
      next_r.alarm = 1'b1;

    // Stop sequence frozen when the alarm fires
    if (ev_alarm)
      next_r.stop_seq = r.alarm_seq;

    // Travel bound latch, released only by a span clear
    if (span_clear)
      next_r.ovf = 1'b0;
    else if (ev_ovf)
      next_r.ovf = 1'b1;

    if (span_clear)
      next_r.quiet = `STL_QUIET_CYC;
    else if (r.quiet != 2'h0)
      next_r.quiet = r.quiet - 2'h1;
  end

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      r           <= '0;
      r.waitreq   <= 1'b1;
      r.margin    <= `STL_RST_MARGIN;
      r.mode      <= `STL_RST_MODE;
      r.alarm_seq <= `STL_RST_SEQ;
      r.ot_seq    <= `STL_RST_SEQ;
      r.status    <= `STL_RST_EV;
      r.mask      <= `STL_RST_EV;
      r.quiet     <= `STL_QUIET_CYC;
    end
    else
      r <= next_r;
  end

  assign o_waitrequest = r.waitreq;
  assign o_readdata    = r.rdata;
  assign o_irq         = r.irq;
  assign o_alarm       = r.alarm;
  assign o_alarm_code  = r.alarm ? `STL_ALARM_CODE : 8'h00;
  assign o_stop_req    = r.alarm;
  assign o_stop_seq    = r.stop_seq;
endmodule

// ### verif/stl_host_model.sv
// Host controller model issuing position command pulses
`timescale 1ns/100ps
module stl_host_model (
  input  wire logic           i_clk,
  output logic                o_cmd_valid,
  output stl_pkg::stl_count_type o_cmd_delta
);
  import stl_pkg::*;
  initial
  begin
    o_cmd_valid = 1'b0;
    o_cmd_delta = '0;
  end
  task automatic send(input stl_count_type d);
    @(posedge i_clk);
    o_cmd_valid <= 1'b1;
    o_cmd_delta <= d;
    @(posedge i_clk);
    o_cmd_valid <= 1'b0;
    // Released delta shows junk so a stale value is never trusted
    o_cmd_delta <= ~d;
  endtask
endmodule

// ### verif/stl_travel_limit_props.sv
// Port-level assertions for the travel limit block
`timescale 1ns/100ps
module stl_tl_chk (
  input wire logic        i_clk,
  input wire logic        i_nrst,
  input wire logic [4:0]  i_address,
  input wire logic        i_read,
  input wire logic        i_write,
  input wire logic [31:0] i_writedata,
  input wire logic        o_waitrequest,
  input wire logic        i_servo_on,
  input wire logic        i_dev_clear,
  input wire logic        i_tool_test,
  input wire logic        o_alarm,
  input wire logic [7:0]  o_alarm_code,
  input wire logic        o_stop_req,
  input wire logic [2:0]  o_stop_seq
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_nrst);
  a_code_follow: assert property (
    o_alarm_code == (o_alarm ? 8'h22 : 8'h00)) else $error("bad code");
  a_alarm_holds: assert property (
    o_alarm && !(i_write && !o_waitrequest && i_address == 5'h00
    && i_writedata[0]) |=> o_alarm) else $error("alarm dropped");
  a_stop_req_eq: assert property (
    o_stop_req == o_alarm) else $error("stop request mismatch");
  a_seq_held: assert property (
    !$rose(o_alarm) |-> $stable(o_stop_seq)) else $error("seq moved");
  a_servo_gate: assert property (
    !i_servo_on [*4] |=> !$rose(o_alarm)) else $error("alarm unpowered");
  a_tool_gate: assert property (
    i_tool_test [*4] |=> !$rose(o_alarm)) else $error("alarm in tool run");
  a_clear_gate: assert property (
    i_dev_clear [*4] |=> !$rose(o_alarm)) else $error("alarm in clear");
  a_wait_one: assert property (
    (i_read || i_write) && o_waitrequest |=> !o_waitrequest)
    else $error("no answer");
  a_wait_idle: assert property (
    !(i_read || i_write) |=> o_waitrequest) else $error("stray answer");
endmodule

bind stl_travel_limit stl_tl_chk u_chk (.*);

// ### verif/testbench.sv
// Self-checking bench for the software travel limit
`timescale 1ns/100ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin num_errors++; \
  $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module testbench;
  import stl_pkg::*;
  logic          clk, nrst, rde, wre, wreq, srv, dclr, oti, tst, tdn;
  logic          tool, irq, alm, sreq, cv, mk;
  logic [4:0]    adr;
  logic [31:0]   wdat, rdat;
  logic [7:0]    code;
  logic [2:0]    sseq, sq;
  stl_count_type cd, mpos;
  int            num_errors, checked;

  stl_travel_limit uut (.i_clk(clk), .i_nrst(nrst), .i_address(adr),
    .i_read(rde), .i_write(wre), .i_writedata(wdat),
    .o_waitrequest(wreq), .o_readdata(rdat), .i_servo_on(srv),
    .i_cmd_valid(cv), .i_cmd_delta(cd), .i_motor_pos(mpos),
    .i_dev_clear(dclr), .i_ot_inhibit(oti), .i_tune_start(tst),
    .i_tune_done(tdn), .i_tool_test(tool), .o_irq(irq), .o_alarm(alm),
    .o_alarm_code(code), .o_stop_req(sreq), .o_stop_seq(sseq));
  stl_host_model host (.i_clk(clk), .o_cmd_valid(cv), .o_cmd_delta(cd));

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    adr  <= a;
    wdat <= d;
    wre  <= 1'b1;
    do @(posedge clk); while (wreq !== 1'b0);
    wre <= 1'b0;
  endtask

  task automatic rd(input logic [4:0] a, output logic [31:0] d);
    @(posedge clk);
    adr <= a;
    rde <= 1'b1;
    do @(posedge clk); while (wreq !== 1'b0);
    d = rdat;
    rde <= 1'b0;
  endtask

  // Motor to p, judge the alarm, then bring it home and clear it
  task automatic trip(input stl_count_type p, input logic e);
    logic [31:0] r;
    @(posedge clk);
    mpos <= p;
    repeat (6) @(posedge clk);
    `CHK(alm, e)
    `CHK(irq, e & mk)
    if (e) `CHK(sseq, sq)
    mpos <= '0;
    repeat (3) @(posedge clk);
    wr(5'h00, 32'h0000_0001);
    rd(5'h0C, r);
    `CHK(r[0], e)
    repeat (2) @(posedge clk);
    `CHK(alm, 1'b0)
    `CHK(irq, 1'b0)
  endtask

  // Hold one clear source for four cycles, then sit out the quiet time
  task automatic pz(input int k);
    @(posedge clk);
    dclr <= (k == 0);
    tst  <= (k == 1);
    tdn  <= (k == 2);
    oti  <= (k == 3);
    repeat (4) @(posedge clk);
    dclr <= 1'b0;
    tst  <= 1'b0;
    tdn  <= 1'b0;
    oti  <= 1'b0;
    repeat (5) @(posedge clk);
  endtask

  task automatic tally_and_finish;
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial
  begin
    #200_000;
    num_errors++;
    tally_and_finish;
  end

  initial
  begin
    logic [31:0] r;
    {nrst, rde, wre, adr, wdat, srv, dclr, oti, tst, tdn, tool} = '0;
    {mpos, sq, mk} = '0;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    rd(5'h04, r);
    `CHK(r, 32'h0000_0000)
    rd(5'h14, r);
    `CHK(r[15:8], 8'h22)
    wr(5'h04, 32'h0000_0064);
    wr(5'h10, 32'h0000_0001);
    mk = 1'b1;
    srv <= 1'b1;
    pz(0);
    trip(100, 1'b0);
    trip(101, 1'b1);
    trip(-101, 1'b1);
    for (int m = 0; m < 16; m++)
    begin
      sq = m[2:0];
      wr(5'h08, 32'(m) | (32'(m % 8) << 4));
      pz(0);
      trip(101, m inside {0, 3, 4, 6});
    end
    sq = 3'h5;
    wr(5'h08, 32'h0000_0050);
    host.send(500);
    trip(600, 1'b0);
    trip(601, 1'b1);
    host.send(-800);
    trip(-400, 1'b0);
    trip(-401, 1'b1);
    host.send(500);
    pz(2);
    trip(200, 1'b1);
    host.send(500);
    pz(1);
    trip(200, 1'b1);
    wr(5'h08, 32'h0000_0250);
    host.send(500);
    pz(3);
    trip(200, 1'b1);
    wr(5'h08, 32'h0000_0050);
    host.send(500);
    pz(3);
    trip(200, 1'b0);
    tool <= 1'b1;
    trip(700, 1'b0);
    tool <= 1'b0;
    host.send(500);
    srv <= 1'b0;
    trip(700, 1'b0);
    srv <= 1'b1;
    repeat (5) @(posedge clk);
    trip(200, 1'b1);
    wr(5'h04, 32'h0000_0000);
    trip(700, 1'b0);
    wr(5'h04, 32'h0000_0064);
    wr(5'h10, 32'h0000_0000);
    mk = 1'b0;
    pz(0);
    trip(700, 1'b1);
    wr(5'h10, 32'h0000_0001);
    mk = 1'b1;
    pz(0);
    @(posedge clk);
    mpos <= 32'h8000_0000;
    repeat (6) @(posedge clk);
    `CHK(alm, 1'b0)
    mpos <= '0;
    rd(5'h0C, r);
    `CHK(r[1], 1'b1)
    trip(200, 1'b0);
    pz(0);
    trip(200, 1'b1);
    tally_and_finish;
  end
endmodule
